/* File: hw/flash_protect.sv */
/*
  Flash option-byte loader, flash read/write protection, system-bus decode of
  the three flash arrays and the on-chip RAM, and an AXI4-Lite command port.
  Assumes rst is the full chip reset from chip_reset_pin, the flash macro sits
  on the same clock, and the system-bus master holds its request until ready.
*/
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module flash_protect
  import flash_protect_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        debug_attached,
  input  wire logic        boot_monitor,
  input  wire logic        fast_clock,
  input  wire sys_req_s    sys_req,
  output sys_rsp_s         sys_rsp,
  output flash_req_s       flash_req,
  input  wire logic [31:0] flash_rdata,
  input  wire logic        flash_busy,
  input  wire axi_req_s    axi_req,
  output axi_rsp_s         axi_rsp,
  output logic             cpu_run,
  output logic             option_error,
  output logic             read_protect,
  output logic             intrusion
);

  typedef struct packed {
    mode_e          mode;
    logic [1:0]     ld_idx;
    logic [7:0][7:0] opt;
    logic           opt_err;
    logic           ld_done;
    logic           rp;
    logic           intr;
    logic           monitor;
    logic           dbg_meta;
    logic           dbg_sync;
    logic           mon_meta;
    logic           mon_sync;
    logic [1:0]     wait_cnt;
    logic           cmd_pend;
    logic [1:0]     cmd;
    logic           chain_erase;
    logic           refused;
    logic [31:0]    target;
    logic [31:0]    hw_data;
    sys_rsp_s       sys;
    flash_req_s     fl;
    logic           aw_got;
    logic           w_got;
    logic [7:0]     aw_off;
    logic [31:0]    w_data;
    logic [3:0]     w_strb;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           rvalid;
    logic [31:0]    rdata;
    logic [1:0]     rresp;
  } state_s;

  state_s      st;
  state_s      next_st;
  logic [31:0] ram [RAM_WORDS];
  logic        ram_we;
  logic [3:0]  ram_lanes;
  logic [11:0] ram_idx;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic decode_s decode(input logic [31:0] a, input logic monitor);
    decode_s d;
    d.area = AREA_NONE;
    d.off  = '0;
    if (a >= MAIN_BASE && a < MAIN_BASE + MAIN_SIZE) begin
      d = '{AREA_MAIN, 18'(a - MAIN_BASE)};
    end else if (a >= FACT_BASE && a < FACT_BASE + INFO_SIZE) begin
      d = '{AREA_FACT, FL_FACT_OFF + 18'(a - FACT_BASE)};
    end else if (a >= USER_BASE && a < USER_BASE + INFO_SIZE) begin
      d = '{AREA_USER, FL_USER_OFF + 18'(a - USER_BASE)};
    end else if (a >= RAM_BASE && a < RAM_BASE + RAM_SIZE) begin
      d = '{AREA_RAM, 18'(a - RAM_BASE)};
    end else if (monitor && a < INFO_SIZE) begin
      d = '{AREA_FACT, FL_FACT_OFF + 18'(a)};
    end else if (!monitor && a < MAIN_SIZE) begin
      d = '{AREA_MAIN, 18'(a)};
    end
    return d;
  endfunction

  // A region is blocked by its active-low option bit or, under read
  // protection, when it is the lowest region holding the reset vector.
  function automatic logic wp_blocks(input logic [17:0] off, input logic [15:0] wp_n,
                                     input logic rp);
    logic [REGION_BITS-1:0] region;
    region = off[REGION_SHIFT +: REGION_BITS];
    return !wp_n[region] || (rp && region == '0);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = val[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------------
  always_comb begin
    decode_s     d;
    decode_s     c;
    logic [15:0] wp_n;
    logic        detached;
    logic        misaligned;
    logic [31:0] word;
    d          = decode(sys_req.addr, st.monitor);
    c          = decode(st.target, st.monitor);
    wp_n       = {st.opt[OPT_WP_HI], st.opt[OPT_WP_LO]};
    detached   = st.rp && st.intr;
    misaligned = (sys_req.size == 2'd1 && sys_req.addr[0])
                 || (sys_req.size == 2'd2 && sys_req.addr[1:0] != 2'b00)
                 || sys_req.size == 2'd3;
    word       = 32'h0;
    next_st    = st;
    ram_we     = 1'b0;
    ram_idx    = d.off[13:2];
    ram_lanes  = 4'h0;

    next_st.sys.ready = 1'b0;
    next_st.sys.error = 1'b0;
    next_st.fl.rd     = 1'b0;
    next_st.fl.prog   = 1'b0;
    next_st.fl.erase  = 1'b0;
    next_st.fl.mass   = 1'b0;
    next_st.dbg_meta  = debug_attached;
    next_st.dbg_sync  = st.dbg_meta;
    next_st.mon_meta  = boot_monitor;
    next_st.mon_sync  = st.mon_meta;
    if (st.dbg_sync) begin
      next_st.intr = 1'b1;
    end

    // AXI4-Lite write side: address and data are taken in either order.
    if (axi_req.awvalid && !st.aw_got) begin
      next_st.aw_got = 1'b1;
      next_st.aw_off = axi_req.awaddr[7:0] & 8'hfc;
    end
    if (axi_req.wvalid && !st.w_got) begin
      next_st.w_got  = 1'b1;
      next_st.w_data = axi_req.wdata;
      next_st.w_strb = axi_req.wstrb;
    end
    if (st.bvalid && axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = RESP_OKAY;
      unique case (st.aw_off)
        REG_TARGET: next_st.target  = merge(st.target, st.w_data, st.w_strb);
        REG_DATA:   next_st.hw_data = merge(st.hw_data, st.w_data, st.w_strb);
        REG_CMD: begin
          if (st.w_strb[0] && st.w_data[1:0] != 2'h0) begin
            if (st.cmd_pend || st.mode == ST_OP_GAP || st.mode == ST_OP_WAIT) begin
              next_st.refused = 1'b1;
            end else begin
              next_st.cmd_pend = 1'b1;
              next_st.cmd      = st.w_data[1:0];
              next_st.refused  = 1'b0;
            end
          end
        end
        REG_STATUS, REG_OPTIONS: next_st.bresp = RESP_OKAY;
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end

    // AXI4-Lite read side.
    if (st.rvalid && axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end else if (axi_req.arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      next_st.rdata  = 32'h0;
      unique case (axi_req.araddr[7:0] & 8'hfc)
        REG_STATUS: begin
          next_st.rdata[ST_LOADED]  = st.ld_done;
          next_st.rdata[ST_OPT_ERR] = st.opt_err;
          next_st.rdata[ST_RPROT]   = st.rp;
          next_st.rdata[ST_INTRUDE] = st.intr;
          next_st.rdata[ST_BUSY]    = st.cmd_pend || st.mode == ST_OP_GAP
                                      || st.mode == ST_OP_WAIT;
          next_st.rdata[ST_REFUSED] = st.refused;
          next_st.rdata[ST_MONITOR] = st.monitor;
        end
        REG_TARGET:  next_st.rdata = st.target;
        REG_DATA:    next_st.rdata = {16'h0, st.hw_data[15:0]};
        REG_OPTIONS: next_st.rdata = {st.opt[OPT_WP_HI], st.opt[OPT_WP_LO],
                                      st.opt[3], st.opt[OPT_RP]};
        REG_CMD:     next_st.rdata = 32'h0;
        default:     next_st.rresp = RESP_SLVERR;
      endcase
    end

    // Main sequencer: option loader, flash commands and system-bus accesses.
    unique case (st.mode)
      ST_BOOT: begin
        if (st.wait_cnt == STRAP_SETTLE) begin
          next_st.monitor  = st.mon_sync;
          next_st.wait_cnt = 2'd0;
          next_st.mode     = ST_LOAD_RD;
        end else begin
          next_st.wait_cnt = st.wait_cnt + 2'd1;
        end
      end
      ST_LOAD_RD: begin
        next_st.fl.rd    = 1'b1;
        next_st.fl.addr  = FL_USER_OFF + {14'h0, st.ld_idx, 2'b00};
        next_st.wait_cnt = FLASH_RD_GAP;
        next_st.mode     = ST_LOAD_CAP;
      end
      ST_LOAD_CAP: begin
        if (st.wait_cnt != 2'd0) begin
          next_st.wait_cnt = st.wait_cnt - 2'd1;
        end else begin
          word = flash_rdata;
          next_st.opt[{st.ld_idx, 1'b0}] = word[7:0];
          next_st.opt[{st.ld_idx, 1'b1}] = word[23:16];
          if (word[15:8] != ~word[7:0] || word[31:24] != ~word[23:16]) begin
            next_st.opt_err = 1'b1;
          end
          if (st.ld_idx == OPT_LAST_WORD) begin
            next_st.ld_done = 1'b1;
            next_st.rp      = st.opt[OPT_RP] != RP_OFF_VALUE;
            next_st.mode    = ST_IDLE;
          end else begin
            next_st.ld_idx = st.ld_idx + 2'd1;
            next_st.mode   = ST_LOAD_RD;
          end
        end
      end
      ST_IDLE: begin
        if (st.cmd_pend) begin
          next_st.cmd_pend = 1'b0;
          next_st.mode     = ST_OP_GAP;
          next_st.fl.addr  = c.off;
          unique case (st.cmd)
            CMD_PROGRAM: begin
              next_st.fl.wdata = st.hw_data[15:0];
              if (c.area == AREA_USER && c.off < FL_USER_OFF + OPT_AREA_BYTES) begin
                next_st.fl.wdata = {~st.hw_data[7:0], st.hw_data[7:0]};
              end
              if (st.target[0] || detached || !(c.area == AREA_MAIN
                  || c.area == AREA_USER) || (c.area == AREA_MAIN
                  && wp_blocks(c.off, wp_n, st.rp))) begin
                next_st.refused = 1'b1;
                next_st.mode    = ST_IDLE;
              end else begin
                next_st.fl.prog = 1'b1;
              end
            end
            CMD_PAGE_ERASE: begin
              next_st.fl.addr = {c.off[17:PAGE_SHIFT], 11'h0};
              if (detached || !(c.area == AREA_MAIN || c.area == AREA_USER)
                  || (c.area == AREA_MAIN && wp_blocks(c.off, wp_n, st.rp))) begin
                next_st.refused = 1'b1;
                next_st.mode    = ST_IDLE;
              end else if (c.area == AREA_USER && st.rp) begin
                next_st.fl.mass     = 1'b1;
                next_st.fl.addr     = 18'h0;
                next_st.chain_erase = 1'b1;
              end else begin
                next_st.fl.erase = 1'b1;
              end
            end
            CMD_MASS_ERASE: begin
              next_st.fl.addr = 18'h0;
              if (detached || st.rp || wp_n != 16'hffff) begin
                next_st.refused = 1'b1;
                next_st.mode    = ST_IDLE;
              end else begin
                next_st.fl.mass = 1'b1;
              end
            end
            default: next_st.mode = ST_IDLE;
          endcase
        end else if (sys_req.valid && !st.sys.ready && st.ld_done) begin
          if (d.area == AREA_NONE || (d.area != AREA_RAM && (detached || sys_req.write))
              || (d.area == AREA_USER && sys_req.fetch)
              || (d.area == AREA_RAM && misaligned)) begin
            next_st.sys.ready = 1'b1;
            next_st.sys.error = 1'b1;
          end else if (d.area == AREA_RAM) begin
            next_st.wait_cnt = fast_clock ? RAM_WAIT_FAST : 2'd0;
            next_st.mode     = ST_RAM;
          end else begin
            next_st.fl.rd    = 1'b1;
            next_st.fl.addr  = {d.off[17:2], 2'b00};
            next_st.wait_cnt = FLASH_RD_GAP;
            next_st.mode     = ST_FLASH_RD;
          end
        end
      end
      ST_FLASH_RD: begin
        if (st.wait_cnt != 2'd0) begin
          next_st.wait_cnt = st.wait_cnt - 2'd1;
        end else begin
          next_st.sys.ready = 1'b1;
          next_st.sys.rdata = flash_rdata;
          next_st.mode      = ST_IDLE;
        end
      end
      ST_RAM: begin
        if (st.wait_cnt != 2'd0) begin
          next_st.wait_cnt = st.wait_cnt - 2'd1;
        end else begin
          unique case (sys_req.size)
            2'd0:    ram_lanes = 4'h1 << sys_req.addr[1:0];
            2'd1:    ram_lanes = sys_req.addr[1] ? 4'hc : 4'h3;
            default: ram_lanes = 4'hf;
          endcase
          ram_we            = sys_req.write;
          next_st.sys.ready = 1'b1;
          next_st.sys.rdata = ram[ram_idx];
          next_st.mode      = ST_IDLE;
        end
      end
      ST_OP_GAP: begin
        next_st.mode = ST_OP_WAIT;
      end
      ST_OP_WAIT: begin
        if (!flash_busy) begin
          if (st.chain_erase) begin
            next_st.chain_erase = 1'b0;
            next_st.fl.erase    = 1'b1;
            next_st.fl.addr     = FL_USER_OFF;
            next_st.mode        = ST_OP_GAP;
          end else begin
            next_st.mode = ST_IDLE;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // State registers and RAM
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      st          <= '0;
      st.mode     <= ST_BOOT;
      st.opt      <= {OPT_COUNT{RST_OPT}};
      st.rp       <= 1'b1;
      st.bresp    <= RESP_OKAY;
      st.rresp    <= RESP_OKAY;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clock) begin
    if (ram_we) begin
      for (int i = 0; i < 4; i++) begin
        if (ram_lanes[i]) begin
          ram[ram_idx][8*i +: 8] <= sys_req.wdata[8*i +: 8];
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign sys_rsp         = st.sys;
  assign flash_req       = st.fl;
  assign cpu_run         = st.ld_done && !st.opt_err;
  assign option_error    = st.opt_err;
  assign read_protect    = st.rp;
  assign intrusion       = st.intr;
  assign axi_rsp.awready = !st.aw_got;
  assign axi_rsp.wready  = !st.w_got;
  assign axi_rsp.bvalid  = st.bvalid;
  assign axi_rsp.bresp   = st.bresp;
  assign axi_rsp.arready = !st.rvalid;
  assign axi_rsp.rvalid  = st.rvalid;
  assign axi_rsp.rdata   = st.rdata;
  assign axi_rsp.rresp   = st.rresp;

endmodule

/* File: shared/flash_protect_pkg.sv */
/*
  Shared constants and carriers for the flash option-byte and protection block.
  Assumes a single 100 MHz system clock and a flash macro that answers reads one
  cycle after it sees a read strobe and raises busy while it programs or erases.
*/
package flash_protect_pkg;

  // ----------------------------------------------------------------------------
  // System address map
  // ----------------------------------------------------------------------------
  localparam logic [31:0] MAIN_BASE = 32'h0800_0000;
  localparam logic [31:0] FACT_BASE = 32'h0804_0000;
  localparam logic [31:0] USER_BASE = 32'h0804_0800;
  localparam logic [31:0] RAM_BASE  = 32'h2000_0000;
  localparam logic [31:0] MAIN_SIZE = 32'h0002_0000;
  localparam logic [31:0] INFO_SIZE = 32'h0000_0800;
  localparam logic [31:0] RAM_SIZE  = 32'h0000_3000;
  localparam int          RAM_WORDS = 3072;

  // ----------------------------------------------------------------------------
  // Flash macro offsets and geometry
  // ----------------------------------------------------------------------------
  localparam logic [17:0] FL_FACT_OFF     = 18'h2_0000;
  localparam logic [17:0] FL_USER_OFF     = 18'h2_0800;
  localparam logic [17:0] OPT_AREA_BYTES  = 18'h0_0010;
  localparam int          PAGE_SHIFT      = 11;
  localparam int          MAIN_PAGES      = 64;
  localparam int          REGION_SHIFT    = 13;
  localparam int          REGION_BITS     = 4;
  localparam int          OPT_COUNT       = 8;
  localparam logic [1:0]  OPT_LAST_WORD   = 2'd3;
  localparam int          OPT_RP          = 0;
  localparam int          OPT_WP_LO       = 4;
  localparam int          OPT_WP_HI       = 5;
  localparam logic [7:0]  RP_OFF_VALUE    = 8'ha5;
  localparam logic [7:0]  RST_OPT         = 8'hff;
  localparam logic [1:0]  RAM_WAIT_FAST   = 2'd2;
  localparam logic [1:0]  FLASH_RD_GAP    = 2'd1;
  localparam logic [1:0]  STRAP_SETTLE    = 2'd2;

  // ----------------------------------------------------------------------------
  // Register map on the AXI4-Lite port
  // ----------------------------------------------------------------------------
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_TARGET  = 8'h04;
  localparam logic [7:0] REG_DATA    = 8'h08;
  localparam logic [7:0] REG_CMD     = 8'h0c;
  localparam logic [7:0] REG_OPTIONS = 8'h10;
  localparam int ST_LOADED   = 0;
  localparam int ST_OPT_ERR  = 1;
  localparam int ST_RPROT    = 2;
  localparam int ST_INTRUDE  = 3;
  localparam int ST_BUSY     = 4;
  localparam int ST_REFUSED  = 5;
  localparam int ST_MONITOR  = 6;
  localparam logic [1:0] CMD_PROGRAM    = 2'h1;
  localparam logic [1:0] CMD_PAGE_ERASE = 2'h2;
  localparam logic [1:0] CMD_MASS_ERASE = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {AREA_NONE, AREA_MAIN, AREA_FACT, AREA_USER, AREA_RAM} area_e;

  typedef enum logic [2:0] {
    ST_BOOT, ST_LOAD_RD, ST_LOAD_CAP, ST_IDLE, ST_FLASH_RD, ST_RAM, ST_OP_GAP, ST_OP_WAIT
  } mode_e;

  typedef struct packed {
    area_e       area;
    logic [17:0] off;
  } decode_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        fetch;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sys_req_s;

  typedef struct packed {
    logic        ready;
    logic        error;
    logic [31:0] rdata;
  } sys_rsp_s;

  typedef struct packed {
    logic        rd;
    logic        prog;
    logic        erase;
    logic        mass;
    logic [17:0] addr;
    logic [15:0] wdata;
  } flash_req_s;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;

endpackage

/* File: testbench/flash_model.sv */
/* Flash macro stand-in: word read one cycle after rd, busy after each change.
   Assumes the option bytes come from the bench; other option words read as erased, other addresses read back their offset. */
`timescale 1ns/10ps
module flash_model
  import flash_protect_pkg::*;
(
  input  wire logic       clock,
  input  wire flash_req_s flash_req,
  input  wire logic [7:0] opt0,
  input  wire logic [7:0] opt4,
  input  wire logic       corrupt,
  output logic [31:0]     flash_rdata = 32'h0,
  output logic            flash_busy,
  output int              n_mass = 0,
  output int              n_prog = 0
);
  logic [1:0] left = 2'h0;
  function automatic logic [15:0] ow(input logic [7:0] d);
    return {~d, d};
  endfunction
  assign flash_busy = left != 2'h0;
  always @(posedge clock) begin
    // Data stands one cycle; toggling exposes stale use.
    if (!flash_req.rd) begin
      flash_rdata <= ~flash_rdata;
    end else if (flash_req.addr[17:4] != FL_USER_OFF[17:4]) begin
      flash_rdata <= {14'h0, flash_req.addr};
    end else begin
      case (flash_req.addr[3:2])
        2'd0: flash_rdata <= {ow(8'hff), ow(opt0) ^ {corrupt, 15'h0}};
        2'd2: flash_rdata <= {ow(8'hff), ow(opt4)};
        default: flash_rdata <= {2{ow(8'hff)}};
      endcase
    end
    left <= (flash_req.prog | flash_req.erase | flash_req.mass) ? 2'h3 : left - (left != 0);
    n_prog <= n_prog + flash_req.prog;
    n_mass <= n_mass + flash_req.mass;
  end
endmodule

/* File: testbench/flash_protect_monitor.sv */
/* Assertions on the ports of flash_protect.
   Assumes single clock, rst synchronous active high, bound to every instance. */
`timescale 1ns/10ps
module flash_protect_monitor
  import flash_protect_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       debug_attached,
  input wire logic       fast_clock,
  input wire sys_req_s   sys_req,
  input wire sys_rsp_s   sys_rsp,
  input wire flash_req_s flash_req,
  input wire logic       cpu_run,
  input wire logic       option_error,
  input wire logic       read_protect,
  input wire logic       intrusion
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  // Aligned word access inside the 12 kB RAM window.
  wire ram = sys_req.addr[31:14] == RAM_BASE[31:14] && sys_req.addr[13:12] != 2'h3
             && sys_req.size == 2'h2 && sys_req.addr[1:0] == 2'h0;
  wire fl = sys_req.addr[31:24] == 8'h08;
  a_err_holds_cpu: assert property (option_error |-> !cpu_run)
    else $error("cpu runs with option error");
  a_detach_err: assert property (sys_rsp.ready && fl && read_protect && intrusion |-> sys_rsp.error)
    else $error("flash answered while detached");
  a_user_nofetch: assert property (sys_rsp.ready && sys_req.fetch && sys_req.addr[31:11] == USER_BASE[31:11] |-> sys_rsp.error)
    else $error("fetch from user array accepted");
  a_ram_norm: assert property ($rose(sys_req.valid) && ram && cpu_run && !fast_clock |-> ##2 sys_rsp.ready)
    else $error("ram answer late");
  a_ram_fast: assert property ($rose(sys_req.valid) && ram && cpu_run && fast_clock |-> ##1 !sys_rsp.ready[*3] ##1 sys_rsp.ready)
    else $error("ram fast answer wrong");
  a_rp_frozen: assert property (cpu_run && $past(cpu_run) |-> $stable(read_protect))
    else $error("read protect changed");
  a_intr_held: assert property (intrusion |=> intrusion)
    else $error("intrusion cleared");
  a_intr_sets: assert property (debug_attached[*6] |-> intrusion)
    else $error("intrusion not set");
  a_boot_wp: assert property (flash_req.prog && read_protect |-> flash_req.addr[17:13] != 5'h0)
    else $error("bottom pages programmed");
  a_opt_compl: assert property (flash_req.prog && flash_req.addr[17:4] == FL_USER_OFF[17:4] |-> flash_req.wdata[15:8] == ~flash_req.wdata[7:0])
    else $error("option complement wrong");
  c_detach: cover property (sys_rsp.ready && sys_rsp.error && intrusion);
  c_prog: cover property (flash_req.prog);
  c_mass: cover property (flash_req.mass);
endmodule
bind flash_protect flash_protect_monitor u_monitor (.clock, .rst, .debug_attached, .fast_clock,
  .sys_req, .sys_rsp, .flash_req, .cpu_run, .option_error, .read_protect, .intrusion);

/* File: testbench/testbench.sv */
/* Self-checking bench for flash_protect.
   Assumes flash_model as flash macro; bench is system-bus and AXI4-Lite master. */
`timescale 1ns/10ps
module testbench
  import flash_protect_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, debug_attached = 1'b0, fast_clock = 1'b0, boot = 1'b0;
  logic [7:0] opt0 = 8'ha5, opt4 = 8'hfe;
  logic corrupt = 1'b0, err, flash_busy, cpu_run, option_error, read_protect, intrusion;
  sys_req_s sys_req = '0;
  sys_rsp_s sys_rsp;
  flash_req_s flash_req;
  axi_req_s axi_req = '0;
  axi_rsp_s axi_rsp;
  logic [31:0] flash_rdata, q, v;
  logic [1:0] r;
  int num_errors = 0, n_compared = 0, n_mass, n_prog, n, k;
  always #5 clock = ~clock;
  flash_protect u_dut (.clock, .rst, .debug_attached, .boot_monitor(boot), .fast_clock,
    .sys_req, .sys_rsp, .flash_req, .flash_rdata, .flash_busy, .axi_req, .axi_rsp,
    .cpu_run, .option_error, .read_protect, .intrusion);
  flash_model u_flash (.clock, .flash_req, .opt0, .opt4, .corrupt, .flash_rdata,
    .flash_busy, .n_mass, .n_prog);
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bound(input logic ok);
    if (!ok) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  task automatic do_reset(input logic [7:0] o0, input logic [7:0] o4, input logic bad,
                          input logic mon);
    opt0 <= o0;
    opt4 <= o4;
    corrupt <= bad;
    boot <= mon;
    rst <= 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (n = 0; n < 40 && !(cpu_run | option_error); n++) @(negedge clock);
    @(posedge clock);
    bound(n < 40);
  endtask
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic [2:0] h;
    logic done;
    done = 1'b0;
    axi_req <= '{awvalid:wr, awaddr:{24'h0, a}, wvalid:wr, wdata:d, wstrb:4'hf,
                 bready:wr, arvalid:!wr, araddr:{24'h0, a}, rready:!wr};
    for (k = 0; k < 50 && !done; k++) begin
      @(negedge clock);
      h = {axi_req.awvalid & axi_rsp.awready, axi_req.wvalid & axi_rsp.wready,
           axi_req.arvalid & axi_rsp.arready};
      done = wr ? axi_rsp.bvalid : axi_rsp.rvalid;
      v = axi_rsp.rdata;
      r = wr ? axi_rsp.bresp : axi_rsp.rresp;
      @(posedge clock);
      if (!done) begin
        axi_req.awvalid <= axi_req.awvalid & !h[2];
        axi_req.wvalid <= axi_req.wvalid & !h[1];
        axi_req.arvalid <= axi_req.arvalid & !h[0];
      end
    end
    bound(done);
    axi_req <= '0;
    @(posedge clock);
  endtask
  task automatic cmd(input logic [31:0] t, input logic [1:0] c);
    axi(1'b1, REG_TARGET, t);
    axi(1'b1, REG_DATA, 32'h1234);
    axi(1'b1, REG_CMD, {30'h0, c});
    for (n = 0; n < 20 && (n == 0 || v[ST_BUSY]); n++) axi(1'b0, REG_STATUS, 32'h0);
    bound(n < 20);
  endtask
  task automatic sys(input logic wr, input logic fe, input logic [31:0] a,
                     input logic [31:0] d, input logic [1:0] sz);
    logic done;
    done = 1'b0;
    sys_req <= '{valid:1'b1, write:wr, fetch:fe, size:sz, addr:a, wdata:d};
    for (n = 0; n < 50 && !done; n++) begin
      @(negedge clock);
      done = sys_rsp.ready;
      err = sys_rsp.error;
      q = sys_rsp.rdata;
      @(posedge clock);
    end
    bound(done);
    sys_req <= '0;
    @(posedge clock);
  endtask
  task automatic t_boot();
    do_reset(8'ha5, 8'hfe, 1'b0, 1'b0);
    cmp(cpu_run, 1'b1);
    cmp(read_protect, 1'b0);
    axi(1'b0, REG_OPTIONS, 32'h0);
    cmp(v, 32'hfffeffa5);
    axi(1'b0, 8'h40, 32'h0);
    cmp(r, RESP_SLVERR);
    $display("t_boot done");
  endtask
  task automatic t_map();
    sys(1'b0, 1'b0, MAIN_BASE + 32'h10, 32'h0, 2'h2);
    cmp(q, 32'h10);
    sys(1'b0, 1'b0, 32'h10, 32'h0, 2'h2);
    cmp(q, 32'h10);
    sys(1'b0, 1'b1, USER_BASE + 32'h4, 32'h0, 2'h2);
    cmp(err, 1'b1);
    sys(1'b1, 1'b0, RAM_BASE + 32'h2ffc, 32'h12345678, 2'h2);
    sys(1'b1, 1'b0, RAM_BASE + 32'h2ffd, 32'h0000ab00, 2'h0);
    sys(1'b0, 1'b0, RAM_BASE + 32'h2ffc, 32'h0, 2'h2);
    cmp(q, 32'h1234ab78);
    cmp(n, 3);
    sys(1'b0, 1'b0, RAM_BASE + RAM_SIZE, 32'h0, 2'h2);
    cmp(err, 1'b1);
    fast_clock <= 1'b1;
    sys(1'b0, 1'b0, RAM_BASE, 32'h0, 2'h2);
    cmp(n, 3 + RAM_WAIT_FAST);
    fast_clock <= 1'b0;
    $display("t_map done");
  endtask
  task automatic t_prot();
    cmd(MAIN_BASE + 32'h10, CMD_PROGRAM);
    cmp(v[ST_REFUSED], 1'b1);
    cmd(MAIN_BASE + 32'h2000, CMD_PROGRAM);
    cmp({v[ST_REFUSED], n_prog[1:0]}, 3'h1);
    cmd(MAIN_BASE + 32'h1800, CMD_PAGE_ERASE);
    cmp(v[ST_REFUSED], 1'b1);
    do_reset(8'hff, 8'hff, 1'b0, 1'b0);
    cmp(read_protect, 1'b1);
    cmd(MAIN_BASE, CMD_PROGRAM);
    cmp(v[ST_REFUSED], 1'b1);
    cmd(USER_BASE, CMD_PROGRAM);
    cmp(n_prog, 2);
    cmd(USER_BASE, CMD_PAGE_ERASE);
    cmp(n_mass, 1);
    debug_attached <= 1'b1;
    repeat (8) @(posedge clock);
    cmp(intrusion, 1'b1);
    sys(1'b0, 1'b0, MAIN_BASE, 32'h0, 2'h2);
    cmp(err, 1'b1);
    debug_attached <= 1'b0;
    repeat (8) @(posedge clock);
    cmp(intrusion, 1'b1);
    do_reset(8'ha5, 8'hff, 1'b0, 1'b1);
    cmp({intrusion, read_protect}, 2'h0);
    sys(1'b0, 1'b0, 32'h10, 32'h0, 2'h2);
    cmp(q, 32'h20010);
    cmd(MAIN_BASE, CMD_MASS_ERASE);
    cmp(n_mass, 2);
    do_reset(8'hff, 8'h00, 1'b1, 1'b0);
    cmp({option_error, cpu_run}, 2'h2);
    $display("t_prot done");
  endtask
  initial begin
    t_boot();
    t_map();
    t_prot();
    tally_and_finish();
  end
endmodule
